// >>> hdl/led_phase_timing_pkg.sv
// Functional notes
// [RULE1] host writes zero into bits 23 to 16
// [RULE2] low 16 bits read/write, reset zero
// [RULE3] led1 drive window from 3h, 4h
// [RULE4] shared ambient2/led3 sample window from 5h, 6h
// [RULE5] led1 sample window from 7h, 8h
// [RULE6] led2 drive window from 9h, Ah
// [RULE7] control bit holds counter in reset
// [RULE8] readback only when readout enable set
// [RULE9] phase active from start through end inclusive
package led_phase_timing_pkg;

    localparam int unsigned addr_width = 8;
    localparam int unsigned data_width = 24;
    localparam int unsigned field_width = 16;
    localparam int unsigned phase_count = 4;

    localparam logic [7:0] control_addr = 8'h00;
    localparam logic [7:0] led1_drive_start_addr = 8'h03;
    localparam logic [7:0] led1_drive_end_addr = 8'h04;
    localparam logic [7:0] amb2_or_led3_sample_start_addr = 8'h05;
    localparam logic [7:0] amb2_or_led3_sample_end_addr = 8'h06;
    localparam logic [7:0] led1_sample_start_addr = 8'h07;
    localparam logic [7:0] led1_sample_end_addr = 8'h08;
    localparam logic [7:0] led2_drive_start_addr = 8'h09;
    localparam logic [7:0] led2_drive_end_addr = 8'h0a;

    localparam int unsigned readout_enable_bit = 0;
    localparam int unsigned timer_hold_in_reset_bit = 1;

    localparam logic [15:0] compare_reset_value = 16'h0000;
    localparam logic [15:0] counter_reset_value = 16'h0000;
    localparam logic [23:0] read_zero_value = 24'h00_0000;

    // phase order in the phase vector
    localparam int unsigned phase_first_emitter_on = 0;
    localparam int unsigned phase_shared_window_sample = 1;
    localparam int unsigned phase_first_emitter_sample = 2;
    localparam int unsigned phase_second_emitter_on = 3;

    typedef struct packed {
        logic write;
        logic read;
        logic [7:0] addr;
        logic [23:0] wdata;
    } reg_request_type;

    typedef struct packed {
        logic [15:0] start;
        logic [15:0] finish;
    } window_type;

endpackage

// >>> hdl/led_phase_timing_regs.sv
`timescale 1ns/1ps
module led_phase_timing_regs #(
    parameter int unsigned count_width = 16,
    parameter logic [15:0] period_count = 16'hffff
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire led_phase_timing_pkg::reg_request_type request_i,
    output logic [23:0] read_data_o,
    output logic read_valid_o,
    output logic [15:0] timer_count_o,
    output logic first_emitter_on_o,
    output logic shared_window_sample_o,
    output logic first_emitter_sample_o,
    output logic second_emitter_on_o
);

    // refused at elaboration: the counter and compare fields share one width
    if (count_width != led_phase_timing_pkg::field_width)
    begin : gen_bad_count_width
        $error("count_width must equal the compare field width");
    end

    // the slot decoder expects one start and one end per window, back to back
    if (led_phase_timing_pkg::led2_drive_end_addr - led_phase_timing_pkg::led1_drive_start_addr
        != 2 * led_phase_timing_pkg::phase_count - 1)
    begin : gen_bad_address_span
        $error("compare address span does not match the window count");
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and compare registers

    logic readout_enable_reg;
    logic timer_hold_in_reset_reg;
    led_phase_timing_pkg::window_type window_reg [led_phase_timing_pkg::phase_count];
    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic [led_phase_timing_pkg::phase_count-1:0] phase_active;

    // slot of a compare address: index, end flag, hit
    function automatic logic [3:0] decode_slot(input logic [7:0] addr);
        logic [7:0] rel;
        rel = addr - led_phase_timing_pkg::led1_drive_start_addr;
        if (addr >= led_phase_timing_pkg::led1_drive_start_addr &&
            addr <= led_phase_timing_pkg::led2_drive_end_addr)
        begin
            decode_slot = {1'b1, rel[2:1], rel[0]};
        end
        else
        begin
            decode_slot = 4'h0;
        end
    endfunction

    logic [3:0] write_slot;
    assign write_slot = decode_slot(request_i.addr);

    // request decode shared by the write and read paths
    logic control_write;
    logic compare_write;
    logic compare_read;
    assign control_write = request_i.write && (request_i.addr == led_phase_timing_pkg::control_addr);
    // [RULE8] timing writes only in write mode
    assign compare_write = request_i.write && write_slot[3] && !readout_enable_reg;
    // [RULE8] readback only when enabled
    assign compare_read = request_i.read && write_slot[3] && readout_enable_reg;

    // [RULE8] readout enable bit
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            readout_enable_reg <= 1'b0;
        end
        else if (control_write)
        begin
            readout_enable_reg <= request_i.wdata[led_phase_timing_pkg::readout_enable_bit];
        end
    end

    // [RULE7] counter hold bit
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            timer_hold_in_reset_reg <= 1'b0;
        end
        else if (control_write)
        begin
            timer_hold_in_reset_reg <= request_i.wdata[led_phase_timing_pkg::timer_hold_in_reset_bit];
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            // [RULE2] compare fields clear
            for (int i = 0; i < led_phase_timing_pkg::phase_count; i++)
            begin
                window_reg[i].start <= led_phase_timing_pkg::compare_reset_value;
                window_reg[i].finish <= led_phase_timing_pkg::compare_reset_value;
            end
        end
        else if (compare_write)
        begin
            // [RULE1] upper bits are dropped, only low field kept
            if (write_slot[0])
            begin
                window_reg[write_slot[2:1]].finish <= request_i.wdata[15:0];
            end
            else
            begin
                window_reg[write_slot[2:1]].start <= request_i.wdata[15:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readback

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            read_valid_o <= 1'b0;
        end
        else
        begin
            // answer strobe one cycle after every read, refused or not
            read_valid_o <= request_i.read;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            read_data_o <= led_phase_timing_pkg::read_zero_value;
        end
        else if (compare_read)
        begin
            read_data_o <= {8'h00, write_slot[0] ? window_reg[write_slot[2:1]].finish
                                                 : window_reg[write_slot[2:1]].start};
        end
        else
        begin
            // [RULE8] refused reads return zero
            read_data_o <= led_phase_timing_pkg::read_zero_value;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // timing counter

    always_comb
    begin
        if (count_reg >= period_count)
        begin
            count_next = led_phase_timing_pkg::counter_reset_value;
        end
        else
        begin
            count_next = count_reg + 16'h0001;
        end
    end

    always_ff @(posedge clk_i)
    begin
        // [RULE7] hold counter in reset
        if (reset_i || timer_hold_in_reset_reg)
        begin
            count_reg <= led_phase_timing_pkg::counter_reset_value;
        end
        else
        begin
            count_reg <= count_next;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            timer_count_o <= led_phase_timing_pkg::counter_reset_value;
        end
        else
        begin
            timer_count_o <= count_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // phase windows: slot 0 led1 drive, 1 shared, 2 led1 sample, 3 led2 drive

    // [RULE3] [RULE4] [RULE5] [RULE6] one compare per window
    for (genvar g = 0; g < led_phase_timing_pkg::phase_count; g++)
    begin : gen_window
        phase_window_compare #(
            .width(16)
        ) compare_inst (
            .clk_i(clk_i),
            .reset_i(reset_i),
            .hold_i(timer_hold_in_reset_reg),
            .count_i(count_reg),
            .start_i(window_reg[g].start),
            .finish_i(window_reg[g].finish),
            .active_o(phase_active[g])
        );
    end

    // [RULE3] first emitter drive
    assign first_emitter_on_o = phase_active[led_phase_timing_pkg::phase_first_emitter_on];

    // [RULE4] shared sample window
    assign shared_window_sample_o = phase_active[led_phase_timing_pkg::phase_shared_window_sample];

    // [RULE5] first emitter sample
    assign first_emitter_sample_o = phase_active[led_phase_timing_pkg::phase_first_emitter_sample];

    // [RULE6] second emitter drive
    assign second_emitter_on_o = phase_active[led_phase_timing_pkg::phase_second_emitter_on];

endmodule

// >>> hdl/phase_window_compare.sv
`timescale 1ns/1ps
module phase_window_compare #(
    parameter int unsigned width = 16
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic hold_i,
    input wire logic [width-1:0] count_i,
    input wire logic [width-1:0] start_i,
    input wire logic [width-1:0] finish_i,
    output logic active_o
);

    always_ff @(posedge clk_i)
    begin
        if (reset_i || hold_i)
        begin
            active_o <= 1'b0;
        end
        else
        begin
            // [RULE9] inclusive window compare
            active_o <= (count_i >= start_i) && (count_i <= finish_i);
        end
    end

endmodule

// >>> tb/host_model.sv
`timescale 1ns/1ps
module host_model (
    input wire logic clk_i,
    input wire logic [23:0] rdata_i,
    output led_phase_timing_pkg::reg_request_type req_o
);
    initial req_o = '0;
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(negedge clk_i);
        req_o = {2'b10, a, 8'h00, d};
        @(negedge clk_i);
        req_o = '0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [23:0] q);
        @(negedge clk_i);
        req_o = {2'b01, a, 24'h00_0000};
        @(negedge clk_i);
        q = rdata_i;
        req_o = '0;
    endtask
endmodule

// >>> tb/led_phase_timing_chk.sv
`timescale 1ns/1ps
module led_phase_timing_chk #(
    parameter logic [15:0] period_count = 16'hffff
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire led_phase_timing_pkg::reg_request_type request_i,
    input wire logic [23:0] read_data_o,
    input wire logic read_valid_o,
    input wire logic [15:0] timer_count_o,
    input wire logic first_emitter_on_o,
    input wire logic shared_window_sample_o,
    input wire logic first_emitter_sample_o,
    input wire logic second_emitter_on_o
);
    logic [15:0] sh_reg [3:10];
    logic en_reg;
    logic hold_reg;
    logic [2:0] settle_reg;
    logic [15:0] c;
    logic in_map;
    assign c = timer_count_o;
    assign in_map = request_i.addr >= 8'h03 && request_i.addr <= 8'h0a;
    default clocking @(posedge clk_i); endclocking
    default disable iff (reset_i);
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            en_reg <= 1'b0;
            hold_reg <= 1'b0;
        end
        else if (request_i.write && request_i.addr == 8'h00)
        begin
            en_reg <= request_i.wdata[0];
            hold_reg <= request_i.wdata[1];
        end
    end
    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            sh_reg <= '{default: 16'h0000};
        else if (request_i.write && !en_reg && in_map)
            sh_reg[request_i.addr] <= request_i.wdata[15:0];
    end
    // cycles since the last write or hold
    always_ff @(posedge clk_i)
    begin
        if (reset_i || hold_reg || request_i.write)
            settle_reg <= 3'h0;
        else if (settle_reg != 3'h7)
            settle_reg <= settle_reg + 3'h1;
    end
    property p_valid; read_valid_o == $past(request_i.read); endproperty
    a_valid: assert property (p_valid) else $error("read valid misplaced");
    property p_rd_off; request_i.read && (!en_reg || !in_map) |=> read_data_o == 24'h00_0000; endproperty
    a_rd_off: assert property (p_rd_off) else $error("refused read not zero");
    property p_rd_val; request_i.read && en_reg && in_map |=> read_data_o == {8'h00, sh_reg[$past(request_i.addr)]};
    endproperty
    a_rd_val: assert property (p_rd_val) else $error("readback wrong");
    property p_hold; hold_reg [*3] |-> c == 16'h0000 && !first_emitter_on_o && !second_emitter_on_o; endproperty
    a_hold: assert property (p_hold) else $error("counter not held");
    property p_led1_on; settle_reg[2] |-> first_emitter_on_o == (c >= sh_reg[3] && c <= sh_reg[4]); endproperty
    a_led1_on: assert property (p_led1_on) else $error("first drive window wrong");
    property p_shared; settle_reg[2] |-> shared_window_sample_o == (c >= sh_reg[5] && c <= sh_reg[6]); endproperty
    a_shared: assert property (p_shared) else $error("shared window wrong");
    property p_led1_smp; settle_reg[2] |-> first_emitter_sample_o == (c >= sh_reg[7] && c <= sh_reg[8]); endproperty
    a_led1_smp: assert property (p_led1_smp) else $error("first sample window wrong");
    property p_led2_on; settle_reg[2] |-> second_emitter_on_o == (c >= sh_reg[9] && c <= sh_reg[10]); endproperty
    a_led2_on: assert property (p_led2_on) else $error("second drive window wrong");
    property p_wrap; timer_count_o <= period_count; endproperty
    a_wrap: assert property (p_wrap) else $error("counter passed its period");
    c_read: cover property (read_valid_o && read_data_o != 24'h00_0000);
    c_hold: cover property (hold_reg [*3]);
    c_phase: cover property ($rose(second_emitter_on_o));
endmodule
bind led_phase_timing_regs led_phase_timing_chk #(.period_count(period_count)) u_chk (.*);

// >>> tb/test_led_phase_timing_regs.sv
`timescale 1ns/1ps
module test_led_phase_timing_regs;
    logic clk_i = 1'b0;
    logic reset_i = 1'b1;
    led_phase_timing_pkg::reg_request_type request_i;
    logic [23:0] read_data_o;
    logic read_valid_o;
    logic [15:0] timer_count_o;
    logic first_emitter_on_o;
    logic shared_window_sample_o;
    logic first_emitter_sample_o;
    logic second_emitter_on_o;
    logic [3:0] ph;
    logic [15:0] win [8] = '{16'h0002, 16'h0005, 16'h0004, 16'h0004, 16'h0006, 16'h0009, 16'h000a, 16'h0014};
    logic [23:0] q;
    int errors = 0;
    int num_checks = 0;
    assign ph = {second_emitter_on_o, first_emitter_sample_o, shared_window_sample_o, first_emitter_on_o};
    always #12.5 clk_i = ~clk_i;
    host_model u_host (.clk_i(clk_i), .rdata_i(read_data_o), .req_o(request_i));
    led_phase_timing_regs #(.period_count(16'h0020)) u_dut (.*);
    task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
        num_checks++;
        if (got !== exp)
        begin
            errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    initial
    begin
        #100us;
        errors++;
        final_report();
    end
    initial
    begin
        repeat (10) @(negedge clk_i);
        reset_i = 1'b0;
        u_host.wr(8'h00, 16'h0001);
        for (int i = 0; i < 8; i++)
        begin
            u_host.rd(8'h03 + 8'(i), q);
            check("reset value", 24'h00_0000, q);
            check("read valid", 24'h00_0001, {23'h00_0000, read_valid_o});
        end
        $display("test reset values done");
        u_host.wr(8'h00, 16'h0000);
        for (int i = 0; i < 8; i++)
            u_host.wr(8'h03 + 8'(i), win[i]);
        u_host.rd(8'h03, q);
        check("read in write mode", 24'h00_0000, q);
        u_host.wr(8'h00, 16'h0001);
        u_host.wr(8'h03, 16'hffff);
        for (int i = 0; i < 8; i++)
        begin
            u_host.rd(8'h03 + 8'(i), q);
            check("readback", {8'h00, win[i]}, q);
        end
        u_host.rd(8'h0b, q);
        check("unmapped read", 24'h00_0000, q);
        $display("test register access done");
        u_host.wr(8'h00, 16'h0003);
        repeat (3) @(negedge clk_i);
        check("held count", 24'h00_0000, {8'h00, timer_count_o});
        check("held phases", 24'h00_0000, {20'h0_0000, ph});
        u_host.wr(8'h00, 16'h0000);
        repeat (40) @(negedge clk_i)
            for (int k = 0; k < 4; k++)
                check("phase", {23'h00_0000, timer_count_o >= win[2 * k] && timer_count_o <= win[2 * k + 1]},
                    {23'h00_0000, ph[k]});
        $display("test phase windows done");
        final_report();
    end
endmodule
